/* src/fspr_host_top.sv */
/*
  Host controller for the status and partition registers of a dual-work
  parallel flash: polls status, requests the page buffer and sets the
  plane grouping, under orders given over AXI4-Lite. Assumes the flash
  pins are asynchronous and the data pins are resolved by the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module fspr_host_top #(
  parameter bit BOTTOM_PARAM = 1'b1  // Bottom-parameter flash when set.
) (
  input  wire logic        CORE_CLK,       // Core clock, 50 MHz.
  input  wire logic        SYS_RST,        // Synchronous reset, active high.
  input  wire logic [7:0]  S_AXI_AWADDR,   // Write address.
  input  wire logic        S_AXI_AWVALID,  // Write address valid.
  output logic             S_AXI_AWREADY,  // Write address ready.
  input  wire logic [31:0] S_AXI_WDATA,    // Write data.
  input  wire logic [3:0]  S_AXI_WSTRB,    // Write byte strobes.
  input  wire logic        S_AXI_WVALID,   // Write data valid.
  output logic             S_AXI_WREADY,   // Write data ready.
  output logic [1:0]       S_AXI_BRESP,    // Write response.
  output logic             S_AXI_BVALID,   // Write response valid.
  input  wire logic        S_AXI_BREADY,   // Write response ready.
  input  wire logic [7:0]  S_AXI_ARADDR,   // Read address.
  input  wire logic        S_AXI_ARVALID,  // Read address valid.
  output logic             S_AXI_ARREADY,  // Read address ready.
  output logic [31:0]      S_AXI_RDATA,    // Read data.
  output logic [1:0]       S_AXI_RRESP,    // Read response.
  output logic             S_AXI_RVALID,   // Read data valid.
  input  wire logic        S_AXI_RREADY,   // Read data ready.
  output logic [19:0]      FLASH_ADDR,     // Flash word address.
  output logic [15:0]      FLASH_DQ_O,     // Flash data out.
  input  wire logic [15:0] FLASH_DQ_I,     // Flash data in.
  output logic             FLASH_DQ_OE_N,  // Low while data pins are driven.
  output logic             FLASH_CE_N,     // Flash chip enable.
  output logic             FLASH_OE_N,     // Flash output enable.
  output logic             FLASH_WE_N,     // Flash write enable.
  input  wire logic        FLASH_RDY       // Ready/busy pin, high when ready.
);

  typedef enum {M_IDLE, M_ISSUE, M_WAIT, M_EVAL} fspr_seq_e;

  fspr_cyc_if cyc ();

  fspr_seq_e          st_q;
  fspr_pkg::fspr_op_e op_q;
  logic [1:0]  step_q;
  logic [3:0]  retry_q;
  logic        req_q;
  logic        busy_q;
  logic        done_q;
  logic        buf_ok_q;
  logic [15:0] sr_q;
  logic [15:0] xsr_q;
  logic [2:0]  pcr_cur_q;
  logic [19:0] addr_q;
  logic [2:0]  pcr_req_q;
  logic        rdy_s1_q;
  logic        rdy_s2_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave decode.
  wire       wr_fire  = S_AXI_AWVALID & S_AXI_WVALID & ~bvalid_q;
  wire       rd_fire  = S_AXI_ARVALID & ~rvalid_q;
  wire [7:0] waddr    = S_AXI_AWADDR;
  wire       wr_ctrl  = wr_fire & (waddr == fspr_pkg::OFS_CTRL);
  wire       wr_addr  = wr_fire & (waddr == fspr_pkg::OFS_ADDR);
  wire       wr_pcr   = wr_fire & (waddr == fspr_pkg::OFS_PCR_REQ);
  wire       wr_stat  = wr_fire & (waddr == fspr_pkg::OFS_STAT);
  wire       wr_known = wr_ctrl | wr_addr | wr_pcr | wr_stat;
  wire       go       = wr_ctrl & S_AXI_WSTRB[0] & S_AXI_WDATA[fspr_pkg::CTRL_GO_BIT] & ~busy_q;
  wire       done_clr = (wr_stat & S_AXI_WSTRB[0] & S_AXI_WDATA[fspr_pkg::STAT_CLR_BIT]) | go;

  assign S_AXI_AWREADY = wr_fire;
  assign S_AXI_WREADY  = wr_fire;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_ARREADY = rd_fire;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RRESP   = rresp_q;
  assign S_AXI_RDATA   = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Status views.
  wire        sr_ready  = sr_q[fspr_pkg::SR_READY_BIT];
  // Bits 6..1 only mean something once ready; the reserved bits never do.
  wire [15:0] sr_view   = sr_q & (sr_ready ? fspr_pkg::SR_VALID_MASK
                                           : fspr_pkg::SR_READY_MASK);
  // Both error bits together mark an improper command sequence.
  wire        improper  = sr_view[fspr_pkg::SR_ERASE_BIT] & sr_view[fspr_pkg::SR_PROG_BIT];
  wire        sr_fault  = improper | sr_view[fspr_pkg::SR_PIN_BIT] | sr_view[fspr_pkg::SR_LOCK_BIT];
  wire [15:0] xsr_view  = xsr_q & fspr_pkg::XSR_VALID_MASK;
  wire [7:0]  pmap      = fspr_pkg::plane_map(pcr_cur_q);
  wire [2:0]  part_cnt  = {1'b0, pmap[7:6]} + 3'h1;
  wire [2:0]  pcr_reset = BOTTOM_PARAM ? fspr_pkg::PCR_RST_BOTTOM : fspr_pkg::PCR_RST_TOP;

  wire [31:0] stat_word = {26'h0, buf_ok_q, sr_fault, improper, rdy_s2_q, done_q, busy_q};
  wire [31:0] pcr_word  = {17'h0, part_cnt, 1'b0, pcr_cur_q, pmap};

  wire [7:0]  raddr     = S_AXI_ARADDR;
  wire        rd_known  = (raddr <= fspr_pkg::OFS_PCR_CUR) & (raddr[1:0] == 2'h0);
  wire [31:0] rd_mux    = (raddr == fspr_pkg::OFS_CTRL)    ? {29'h0, op_q, busy_q} :
                          (raddr == fspr_pkg::OFS_ADDR)    ? {12'h0, addr_q} :
                          (raddr == fspr_pkg::OFS_PCR_REQ) ? {21'h0, pcr_req_q, 8'h00} :
                          (raddr == fspr_pkg::OFS_STAT)    ? stat_word :
                          (raddr == fspr_pkg::OFS_SR)      ? {16'h0, sr_view} :
                          (raddr == fspr_pkg::OFS_XSR)     ? {16'h0, xsr_view} :
                          (raddr == fspr_pkg::OFS_PCR_CUR) ? pcr_word : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle table: what the sequencer puts on the flash bus at each step.
  wire rd_step = ((op_q == fspr_pkg::OP_POLL) & (step_q == 2'h1)) |
                 ((op_q == fspr_pkg::OP_BUF)  & (step_q == 2'h1)) |
                 ((op_q == fspr_pkg::OP_PCR)  & (step_q == 2'h2));
  wire [7:0] cmd = (op_q == fspr_pkg::OP_POLL)  ? fspr_pkg::CMD_READ_STATUS :
                   (op_q == fspr_pkg::OP_BUF)   ? fspr_pkg::CMD_BUF_PROGRAM :
                   (op_q == fspr_pkg::OP_CLEAR) ? fspr_pkg::CMD_CLEAR_STATUS :
                   (step_q == 2'h0)             ? fspr_pkg::CMD_PCR_SETUP :
                                                  fspr_pkg::CMD_PCR_CONFIRM;
  // The confirm cycle carries the new field on the address lines.
  wire pcr_conf = (op_q == fspr_pkg::OP_PCR) & (step_q == 2'h1);
  wire [19:0] pcr_addr = {addr_q[19:11], pcr_req_q, addr_q[7:0]};

  assign cyc.req   = req_q;
  assign cyc.we    = ~rd_step;
  assign cyc.addr  = pcr_conf ? pcr_addr : addr_q;
  assign cyc.wdata = {8'h00, cmd};

  wire [15:0] rd_val   = cyc.rdata;
  wire        rd_ready = rd_val[fspr_pkg::SR_READY_BIT];
  wire        rd_avail = rd_val[fspr_pkg::XSR_AVAIL_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave registers.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      bvalid_q  <= 1'b0;
      bresp_q   <= fspr_pkg::RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= fspr_pkg::RESP_OKAY;
      rdata_q   <= 32'h0;
      addr_q    <= 20'h00000;
      pcr_req_q <= 3'h0;
    end else begin
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_known ? fspr_pkg::RESP_OKAY : fspr_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rresp_q  <= rd_known ? fspr_pkg::RESP_OKAY : fspr_pkg::RESP_SLVERR;
        rdata_q  <= rd_mux;
      end else if (S_AXI_RREADY) begin
        rvalid_q <= 1'b0;
      end
      if (wr_addr & ~busy_q) begin
        addr_q <= {S_AXI_WSTRB[2] ? S_AXI_WDATA[19:16] : addr_q[19:16],
                   S_AXI_WSTRB[1] ? S_AXI_WDATA[15:8]  : addr_q[15:8],
                   S_AXI_WSTRB[0] ? S_AXI_WDATA[7:0]   : addr_q[7:0]};
      end
      if (wr_pcr & ~busy_q & S_AXI_WSTRB[1]) begin
        pcr_req_q <= S_AXI_WDATA[10:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ready pin synchroniser; only the second stage is read.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      rdy_s1_q <= 1'b0;
      rdy_s2_q <= 1'b0;
    end else begin
      rdy_s1_q <= FLASH_RDY;
      rdy_s2_q <= rdy_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer. Polling has no bound of its own: a flash that never comes
  // ready keeps the controller busy until reset.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      st_q      <= M_IDLE;
      op_q      <= fspr_pkg::OP_POLL;
      step_q    <= 2'h0;
      retry_q   <= 4'h0;
      req_q     <= 1'b0;
      busy_q    <= 1'b0;
      done_q    <= 1'b0;
      buf_ok_q  <= 1'b0;
      sr_q      <= 16'h0000;
      xsr_q     <= 16'h0000;
      pcr_cur_q <= 3'h0;
    end else begin
      req_q <= 1'b0;
      if (done_clr) begin
        done_q <= 1'b0;
      end
      if (st_q == M_IDLE && !busy_q && !done_q && pcr_cur_q == 3'h0 && sr_q == 16'h0000) begin
        pcr_cur_q <= pcr_reset;
      end
      case (st_q)
        M_IDLE: begin
          if (go) begin
            st_q    <= M_ISSUE;
            op_q    <= fspr_pkg::fspr_op_e'(S_AXI_WDATA[fspr_pkg::CTRL_OP_LSB +: 2]);
            step_q  <= 2'h0;
            retry_q <= 4'h0;
            busy_q  <= 1'b1;
          end
        end
        M_ISSUE: begin
          req_q <= 1'b1;
          st_q  <= M_WAIT;
        end
        M_WAIT: begin
          if (cyc.done) begin
            st_q <= M_EVAL;
          end
        end
        M_EVAL: begin
          st_q <= M_ISSUE;
          if (rd_step && op_q == fspr_pkg::OP_BUF) begin
            xsr_q   <= rd_val;
            retry_q <= retry_q + 4'h1;
            if (rd_avail || retry_q == fspr_pkg::BUF_RETRY_MAX - 4'h1) begin
              buf_ok_q <= rd_avail;
              st_q     <= M_IDLE;
            end else begin
              step_q <= 2'h0;
            end
          end else if (rd_step) begin
            sr_q <= rd_val;
            if (rd_ready) begin
              st_q <= M_IDLE;
              // The field is taken only on a clean completion.
              if (op_q == fspr_pkg::OP_PCR && (rd_val & fspr_pkg::SR_VALID_MASK) ==
                  fspr_pkg::SR_READY_MASK) begin
                pcr_cur_q <= pcr_req_q;
              end
            end
          end else if (op_q == fspr_pkg::OP_CLEAR) begin
            st_q <= M_IDLE;
          end else begin
            step_q <= step_q + 2'h1;
          end
          if (st_q == M_EVAL && (op_q == fspr_pkg::OP_CLEAR ||
              (rd_step && (rd_ready || op_q == fspr_pkg::OP_BUF) &&
               (op_q != fspr_pkg::OP_BUF || rd_avail ||
                retry_q == fspr_pkg::BUF_RETRY_MAX - 4'h1)))) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
        default: st_q <= M_IDLE;
      endcase
    end
  end

  fspr_flash_cycle u_cycle (
    .clk     (CORE_CLK),
    .rst     (SYS_RST),
    .cyc     (cyc.engine),
    .fa      (FLASH_ADDR),
    .dq_o    (FLASH_DQ_O),
    .dq_i    (FLASH_DQ_I),
    .dq_oe_n (FLASH_DQ_OE_N),
    .ce_n    (FLASH_CE_N),
    .oe_n    (FLASH_OE_N),
    .we_n    (FLASH_WE_N)
  );

endmodule
`default_nettype wire

/* src/fspr_pkg.sv */
/*
  Constants, types and decode helpers shared by the flash status and
  partition host controller. Assumes a 50 MHz core clock and a 16-bit
  asynchronous flash bus with a 20-bit word address.
*/
package fspr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned T_ACC_NS      = 60;
  localparam int unsigned T_WP_NS       = 50;
  localparam int unsigned SYNC_STAGES   = 2;
  localparam int unsigned ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WP_CYC  = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] RD_CNT   = 4'(ACC_CYC + SYNC_STAGES);
  localparam logic [3:0] WR_CNT   = 4'(WP_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // Flash bus widths and command codes.
  localparam int unsigned FA_W = 20;
  localparam int unsigned DQ_W = 16;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_BUF_PROGRAM  = 8'he8;
  localparam logic [7:0] CMD_PCR_SETUP    = 8'h60;
  localparam logic [7:0] CMD_PCR_CONFIRM  = 8'h04;

  ////////////////////////////////////////////////////////////////////////////
  // Device register fields.
  localparam int unsigned SR_READY_BIT  = 7;
  localparam int unsigned SR_ERASE_BIT  = 5;
  localparam int unsigned SR_PROG_BIT   = 4;
  localparam int unsigned SR_PIN_BIT    = 3;
  localparam int unsigned SR_LOCK_BIT   = 1;
  localparam int unsigned XSR_AVAIL_BIT = 7;
  localparam int unsigned PCR_FIELD_LSB = 8;
  localparam logic [15:0] SR_VALID_MASK  = 16'h00fe;
  localparam logic [15:0] SR_READY_MASK  = 16'h0080;
  localparam logic [15:0] XSR_VALID_MASK = 16'h0080;
  localparam logic [2:0]  PCR_RST_BOTTOM = 3'h1;
  localparam logic [2:0]  PCR_RST_TOP    = 3'h4;
  localparam logic [3:0]  BUF_RETRY_MAX  = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Controller register map (byte offsets) and fields.
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_ADDR    = 8'h04;
  localparam logic [7:0] OFS_PCR_REQ = 8'h08;
  localparam logic [7:0] OFS_STAT    = 8'h0c;
  localparam logic [7:0] OFS_SR      = 8'h10;
  localparam logic [7:0] OFS_XSR     = 8'h14;
  localparam logic [7:0] OFS_PCR_CUR = 8'h18;
  localparam int unsigned CTRL_GO_BIT  = 0;
  localparam int unsigned CTRL_OP_LSB  = 1;
  localparam int unsigned STAT_CLR_BIT = 1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {OP_POLL, OP_BUF, OP_CLEAR, OP_PCR} fspr_op_e;

  // Partition index of each plane, packed {plane3, plane2, plane1, plane0}.
  function automatic logic [7:0] plane_map(input logic [2:0] field);
    case (field)
      3'h0:    plane_map = 8'h00;
      3'h1:    plane_map = 8'h54;
      3'h2:    plane_map = 8'h50;
      3'h3:    plane_map = 8'ha4;
      3'h4:    plane_map = 8'h40;
      3'h5:    plane_map = 8'h94;
      3'h6:    plane_map = 8'h90;
      default: plane_map = 8'he4;
    endcase
  endfunction

endpackage

/* src/fspr_cyc_if.sv */
/*
  Request and answer signals between the host sequencer and the flash bus
  cycle engine. Assumes both ends run on the same core clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface fspr_cyc_if;
  logic        req;
  logic        we;
  logic [19:0] addr;
  logic [15:0] wdata;
  logic        done;
  logic [15:0] rdata;
  modport master (output req, we, addr, wdata, input done, rdata);
  modport engine (input req, we, addr, wdata, output done, rdata);
endinterface
`default_nettype wire

/* src/fspr_flash_cycle.sv */
/*
  Flash bus cycle engine: runs one asynchronous read or write cycle per
  request pulse. Assumes requests come only while it is idle.
*/
`timescale 1ns/100ps
`default_nettype none
module fspr_flash_cycle (
  input  wire logic        clk,      // Core clock.
  input  wire logic        rst,      // Synchronous reset, active high.
  fspr_cyc_if.engine       cyc,      // Cycle requests from the sequencer.
  output logic [19:0]      fa,       // Flash word address.
  output logic [15:0]      dq_o,     // Data driven to the flash.
  input  wire logic [15:0] dq_i,     // Data pins as seen from the flash.
  output logic             dq_oe_n,  // Low while the data pins are driven.
  output logic             ce_n,     // Chip enable.
  output logic             oe_n,     // Output enable.
  output logic             we_n      // Write enable.
);

  typedef enum {E_IDLE, E_ACT, E_REC} fspr_eng_e;

  fspr_eng_e   st_q;
  logic [3:0]  cnt_q;
  logic        we_q;
  logic [15:0] dq_s1_q;
  logic [15:0] dq_s2_q;
  logic        done_q;
  logic [15:0] rdata_q;

  assign cyc.done  = done_q;
  assign cyc.rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // The read count includes the two synchroniser stages, so the sample
  // taken at the end reflects the pins as they stood one access time after the cycle began.
  always_ff @(posedge clk) begin
    dq_s1_q <= dq_i;
    dq_s2_q <= dq_s1_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q    <= E_IDLE;
      cnt_q   <= 4'h0;
      we_q    <= 1'b0;
      fa      <= 20'h00000;
      dq_o    <= 16'h0000;
      dq_oe_n <= 1'b1;
      ce_n    <= 1'b1;
      oe_n    <= 1'b1;
      we_n    <= 1'b1;
      done_q  <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        E_IDLE: begin
          if (cyc.req) begin
            st_q    <= E_ACT;
            we_q    <= cyc.we;
            fa      <= cyc.addr;
            dq_o    <= cyc.wdata;
            dq_oe_n <= ~cyc.we;
            ce_n    <= 1'b0;
            we_n    <= ~cyc.we;
            oe_n    <= cyc.we;
            cnt_q   <= cyc.we ? fspr_pkg::WR_CNT : fspr_pkg::RD_CNT;
          end
        end
        E_ACT: begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h1) begin
            st_q <= E_REC;
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
            if (!we_q) begin
              rdata_q <= dq_s2_q;
            end
          end
        end
        E_REC: begin
          // Write data is held one cycle past the rising write enable.
          st_q    <= E_IDLE;
          dq_oe_n <= 1'b1;
          done_q  <= 1'b1;
        end
        default: st_q <= E_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

/* verification/fspr_host_asserts.sv */
/*
  Port checks for the flash status and partition host controller.
  Assumes one core clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module fspr_host_asserts (
  input wire logic        CORE_CLK,       // Clock.
  input wire logic        SYS_RST,        // Reset.
  input wire logic        S_AXI_AWVALID,  // Write address valid.
  input wire logic        S_AXI_WVALID,   // Write data valid.
  input wire logic        S_AXI_BVALID,   // Write response valid.
  input wire logic [7:0]  S_AXI_ARADDR,   // Read address.
  input wire logic        S_AXI_ARVALID,  // Read address valid.
  input wire logic        S_AXI_ARREADY,  // Read address ready.
  input wire logic [31:0] S_AXI_RDATA,    // Read data.
  input wire logic        S_AXI_RVALID,   // Read data valid.
  input wire logic        S_AXI_RREADY,   // Read data ready.
  input wire logic        FLASH_DQ_OE_N,  // Data drive, low active.
  input wire logic        FLASH_OE_N,     // Output enable.
  input wire logic        FLASH_WE_N      // Write enable.
);
  // The register being answered is only known from the accepted address.
  logic [7:0] ra_q;
  always_ff @(posedge CORE_CLK) begin
    if (S_AXI_ARVALID && S_AXI_ARREADY) ra_q <= S_AXI_ARADDR;
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  ////////////////////////////////////////////////////////////////
  a_write_answer: assert property (S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID |=> S_AXI_BVALID)
    else $error("write not answered");
  a_read_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer dropped");
  a_sr_reserved: assert property (S_AXI_RVALID && ra_q == fspr_pkg::OFS_SR
    |-> S_AXI_RDATA[31:8] == 24'h0 && !S_AXI_RDATA[0]) else $error("status reserved bits seen");
  a_sr_busy_bits: assert property (S_AXI_RVALID && ra_q == fspr_pkg::OFS_SR
    && !S_AXI_RDATA[7] |-> S_AXI_RDATA[6:1] == 6'h0) else $error("busy status not masked");
  a_xsr_reserved: assert property (S_AXI_RVALID && ra_q == fspr_pkg::OFS_XSR
    |-> (S_AXI_RDATA & ~32'h80) == 32'h0) else $error("extended reserved bits seen");
  a_write_pulse: assert property ($fell(FLASH_WE_N) |-> !FLASH_WE_N [*3] ##1 FLASH_WE_N)
    else $error("write pulse length wrong");
  a_read_pulse: assert property ($fell(FLASH_OE_N) |-> !FLASH_OE_N [*5] ##1 FLASH_OE_N)
    else $error("read pulse length wrong");
  a_no_contention: assert property (!FLASH_OE_N |-> FLASH_DQ_OE_N)
    else $error("data driven during read");
endmodule
`default_nettype wire

/* verification/fspr_flash_model.sv */
/*
  Behavioural flash device: status, extended status and plane grouping.
  Assumes the bench resolves the data pins and sets the knobs.
*/
`timescale 1ns/100ps
`default_nettype none
module fspr_flash_model #(
  parameter bit BOTTOM = 1'b1  // Bottom-parameter device when set.
) (
  input  wire logic [19:0] fa,    // Word address.
  input  wire logic [15:0] dq,    // Resolved data pins.
  input  wire logic        ce_n,  // Chip enable.
  input  wire logic        oe_n,  // Output enable.
  input  wire logic        we_n,  // Write enable.
  output logic      [15:0] q,     // Data the device offers.
  output logic             rdy    // High when ready.
);
  logic [15:0] sr_raw  = 16'h0080;
  logic [7:0]  cmd     = 8'hff;
  logic [7:0]  prev    = 8'hff;
  logic [2:0]  field   = BOTTOM ? 3'h1 : 3'h4;
  logic [19:0] last_fa = 20'h0;
  int          busy    = 0;
  int          refuse  = 0;
  logic [15:0] val;
  // While busy the low bits carry junk, so a host that trusts them is caught.
  assign val = cmd == 8'he8 ? {8'h5a, refuse == 0, 7'h35}
             : busy > 0 ? {sr_raw[15:8], 1'b0, ~sr_raw[6:0]} : sr_raw;
  // A released bus shows the inverse, never a stale copy of the answer.
  assign q = (!ce_n && !oe_n) ? val : ~val;
  assign rdy = busy == 0;
  always @(posedge we_n) begin
    prev = cmd;
    cmd = dq[7:0];
    last_fa = fa;
    if (cmd == 8'h50) sr_raw = sr_raw & 16'hffc5;
    if (prev == 8'h60 && cmd == 8'h04 && sr_raw[5:4] != 2'b11) field = fa[10:8];
  end
  always @(posedge oe_n) begin
    if (cmd == 8'he8 && refuse > 0) refuse = refuse - 1;
    else if (busy > 0) busy = busy - 1;
  end
endmodule
`default_nettype wire

/* verification/fspr_host_top_bench.sv */
/*
  Self-checking bench for fspr_host_top with a behavioural flash device.
  Assumes the device model answers on the resolved data pins.
*/
`timescale 1ns/100ps
`default_nettype none
module fspr_host_top_bench;
  localparam logic [7:0]  MAP [8] = '{8'h00, 8'h54, 8'h50, 8'ha4, 8'h40, 8'h94, 8'h90, 8'he4};
  localparam logic [2:0]  CNT [8] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h2, 3'h3, 3'h3, 3'h4};
  localparam logic [15:0] STS [8] = '{16'h80, 16'hc0, 16'ha0, 16'h90, 16'h88, 16'h84, 16'h82, 16'hb0};
  logic        CORE_CLK, SYS_RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID;
  logic        S_AXI_RREADY, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic        S_AXI_RVALID, FLASH_DQ_OE_N, FLASH_CE_N, FLASH_OE_N, FLASH_WE_N, FLASH_RDY;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd_val;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic [19:0] FLASH_ADDR, adr;
  logic [15:0] FLASH_DQ_O, FLASH_DQ_I, dev_q, sr;
  logic [65:0] rq[$], e;
  logic [1:0]  wq[$];
  int          n_fail = 0;
  int          n_compared = 0;
  assign FLASH_DQ_I = FLASH_DQ_OE_N ? dev_q : FLASH_DQ_O;
  fspr_host_top #(.BOTTOM_PARAM(1'b1)) fspr_host_top_inst (.*);
  fspr_flash_model fspr_flash_model_inst (.fa(FLASH_ADDR), .dq(FLASH_DQ_I), .ce_n(FLASH_CE_N),
    .oe_n(FLASH_OE_N), .we_n(FLASH_WE_N), .q(dev_q), .rdy(FLASH_RDY));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Both tasks are entered just after a rising edge and return on one.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    wq.push_back(r);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    fork
      begin
        do @(posedge CORE_CLK); while (S_AXI_AWREADY !== 1'b1);
        S_AXI_AWVALID <= 1'b0;
      end
      begin
        do @(posedge CORE_CLK); while (S_AXI_WREADY !== 1'b1);
        S_AXI_WVALID <= 1'b0;
      end
    join
    while (S_AXI_BVALID !== 1'b1) @(posedge CORE_CLK);
  endtask
  // The note holds {mask, response, data}; a zero mask only checks the response.
  task automatic axi_rd(input logic [7:0] a, input logic [65:0] n);
    rq.push_back(n);
    S_AXI_ARADDR <= a;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    do @(posedge CORE_CLK); while (S_AXI_ARREADY !== 1'b1);
    S_AXI_ARVALID <= 1'b0;
    while (S_AXI_RVALID !== 1'b1) @(posedge CORE_CLK);
    rd_val = S_AXI_RDATA;
  endtask
  task automatic run_op(input logic [1:0] op);
    axi_wr(fspr_pkg::OFS_CTRL, {29'h0, op, 1'b1}, fspr_pkg::RESP_OKAY);
    do begin
      axi_rd(fspr_pkg::OFS_SR, 66'h0);
      axi_rd(fspr_pkg::OFS_STAT, 66'h0);
    end while (rd_val[1] !== 1'b1);
  endtask
  always @(posedge CORE_CLK) begin
    if (S_AXI_RVALID && S_AXI_RREADY) begin
      e = rq.pop_front();
      check(S_AXI_RDATA & e[65:34], e[31:0] & e[65:34]);
      check({30'h0, S_AXI_RRESP}, {30'h0, e[33:32]});
    end
    if (S_AXI_BVALID && S_AXI_BREADY) check({30'h0, S_AXI_BRESP}, {30'h0, wq.pop_front()});
  end
  initial begin
    CORE_CLK = 1'b0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end
  initial begin
    #1500000;
    n_fail++;
    end_sim;
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    {SYS_RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 6'h20;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h0;
    S_AXI_WSTRB = 4'hf;
    void'($urandom(32'h9f0f));
    repeat (10) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    axi_rd(fspr_pkg::OFS_PCR_CUR, {~32'h0, 2'h0, 17'h0, CNT[1], 1'b0, 3'h1, MAP[1]});
    adr = 20'($urandom);
    axi_wr(fspr_pkg::OFS_ADDR, {12'h0, adr}, fspr_pkg::RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      sr = STS[i] | {8'($urandom), 7'h0, 1'($urandom)};
      fspr_flash_model_inst.sr_raw = sr;
      fspr_flash_model_inst.busy = i % 4;
      run_op(fspr_pkg::OP_POLL);
      check({12'h0, fspr_flash_model_inst.last_fa}, {12'h0, adr});
      axi_rd(fspr_pkg::OFS_SR, {~32'h0, 2'h0, 16'h0, sr & 16'hfe});
      axi_rd(fspr_pkg::OFS_STAT, {32'h1f, 2'h0, 27'h0, sr[5] & sr[4] | sr[3] | sr[1],
        sr[5] & sr[4], 3'h6});
    end
    run_op(fspr_pkg::OP_CLEAR);
    run_op(fspr_pkg::OP_POLL);
    axi_rd(fspr_pkg::OFS_SR, {~32'h0, 2'h0, 16'h0, sr & 16'hc4});
    for (int i = 0; i < 3; i++) begin
      fspr_flash_model_inst.refuse = (i == 0) ? 0 : 6 + i;
      run_op(fspr_pkg::OP_BUF);
      axi_rd(fspr_pkg::OFS_STAT, {32'h20, 2'h0, 26'h0, 1'(i < 2), 5'h0});
      axi_rd(fspr_pkg::OFS_XSR, {~32'h0, 2'h0, 24'h0, 1'(i < 2), 7'h0});
    end
    fspr_flash_model_inst.sr_raw = 16'hff81;
    for (int f = 0; f < 8; f++) begin
      fspr_flash_model_inst.busy = 2;
      axi_wr(fspr_pkg::OFS_PCR_REQ, {21'h0, 3'(f), 8'h0}, fspr_pkg::RESP_OKAY);
      run_op(fspr_pkg::OP_PCR);
      check({12'h0, fspr_flash_model_inst.last_fa}, {12'h0, adr[19:11], 3'(f), adr[7:0]});
      axi_rd(fspr_pkg::OFS_PCR_CUR, {~32'h0, 2'h0, 17'h0, CNT[f], 1'b0, 3'(f), MAP[f]});
    end
    fspr_flash_model_inst.sr_raw = 16'h00b0;
    axi_wr(fspr_pkg::OFS_PCR_REQ, 32'h300, fspr_pkg::RESP_OKAY);
    run_op(fspr_pkg::OP_PCR);
    axi_rd(fspr_pkg::OFS_PCR_CUR, {~32'h0, 2'h0, 17'h0, CNT[7], 1'b0, 3'h7, MAP[7]});
    axi_wr(8'h40, 32'h0, fspr_pkg::RESP_SLVERR);
    axi_rd(8'h1c, {~32'h0, fspr_pkg::RESP_SLVERR, 32'h0});
    axi_rd(8'h02, {~32'h0, fspr_pkg::RESP_SLVERR, 32'h0});
    end_sim;
  end
endmodule
bind fspr_host_top fspr_host_asserts fspr_host_asserts_inst (.CORE_CLK, .SYS_RST, .S_AXI_AWVALID,
  .S_AXI_WVALID, .S_AXI_BVALID, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
  .S_AXI_RVALID, .S_AXI_RREADY, .FLASH_DQ_OE_N, .FLASH_OE_N, .FLASH_WE_N);
`default_nettype wire
